// ### apwm_driver.sv
// Purpose: audio pwm speaker driver with axi4-lite registers
// Assumes: single clock mclk at 20 MHz, cpu_sleep is synchronous
// Notes: gain is a digital scale of the sample before pwm
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "apwm_map.svh"
module apwm_driver
    import apwm_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic cpu_sleep,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic speaker_out_a,
    output logic speaker_out_a_oe_n,
    output logic speaker_out_b,
    output logic speaker_out_b_oe_n
);
    logic [7:0] volume_mute_control;
    apwm_ctrl_t ctrl;
    logic [7:0] play_sample_low_byte;
    logic [7:0] play_sample_high_byte;
    logic [15:0] sample;
    logic [4:0] aw_addr;
    logic aw_held;
    logic [7:0] w_byte;
    logic w_held;
    apwm_state_t state;
    apwm_state_t next_state;
    logic [8:0] pwm_cnt;
    logic [8:0] duty;
    logic [15:0] gained;

    // gain table: q8 multiplier, 256 is unity; codes outside range are reserved
    function automatic logic [9:0] gain_mult(input logic [6:0] code);
        logic [9:0] m;
        m = 10'd256;
        case (code)
            7'h0C: m = 10'd511; 7'h0B: m = 10'd482; 7'h0A: m = 10'd455;
            7'h09: m = 10'd430; 7'h08: m = 10'd406; 7'h07: m = 10'd383;
            7'h06: m = 10'd362; 7'h05: m = 10'd341; 7'h04: m = 10'd322;
            7'h03: m = 10'd304; 7'h02: m = 10'd287; 7'h01: m = 10'd271;
            7'h00: m = 10'd256; 7'h7F: m = 10'd242; 7'h7E: m = 10'd228;
            7'h7D: m = 10'd215; 7'h7C: m = 10'd203; 7'h7B: m = 10'd192;
            7'h7A: m = 10'd181; 7'h79: m = 10'd171; 7'h78: m = 10'd162;
            7'h77: m = 10'd152; 7'h76: m = 10'd144; 7'h75: m = 10'd136;
            7'h74: m = 10'd128; 7'h73: m = 10'd121; 7'h72: m = 10'd114;
            7'h71: m = 10'd108; 7'h70: m = 10'd102; 7'h6F: m = 10'd96;
            7'h6E: m = 10'd91; 7'h6D: m = 10'd86; 7'h6C: m = 10'd81;
            7'h6B: m = 10'd76; 7'h6A: m = 10'd72; 7'h69: m = 10'd68;
            7'h68: m = 10'd64; 7'h67: m = 10'd57; 7'h66: m = 10'd51;
            7'h65: m = 10'd45; 7'h64: m = 10'd40; 7'h63: m = 10'd36;
            7'h62: m = 10'd32; 7'h61: m = 10'd29; 7'h60: m = 10'd26;
            7'h5F: m = 10'd23; 7'h5E: m = 10'd20; 7'h5D: m = 10'd18;
            7'h5C: m = 10'd16; 7'h5B: m = 10'd14; 7'h5A: m = 10'd13;
            7'h59: m = 10'd11; 7'h58: m = 10'd10; 7'h57: m = 10'd9;
            7'h56: m = 10'd8; 7'h55: m = 10'd7; 7'h54: m = 10'd6;
            default: m = 10'd256;
        endcase
        return m;
    endfunction

    // bus decode: write fires once address and data are both held
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire [4:0] rd_addr = s_axi_araddr;
    wire active = ctrl.enable && !cpu_sleep;
    wire [3:0] nbits = 4'd6 + {2'b00, ctrl.res_sel};
    wire [8:0] top_count = 9'((10'd1 << nbits) - 10'd1);
    wire [15:0] play_value = volume_mute_control[`APWM_BIT_UNMUTE] ? gained
                             : `APWM_MUTE_VALUE;
    wire [8:0] duty_next = 9'(play_value >> (5'd16 - {1'b0, nbits}));
    wire period_end = (pwm_cnt >= top_count);
    wire pwm_level = (pwm_cnt < duty);
    wire [7:0] ctrl_rd = {ctrl.mode, ctrl.res_sel, 4'h0, ctrl.enable};

    // signed sample scaled by gain, saturated to 16 bits
    logic signed [26:0] prod;
    always_comb begin
        prod = $signed(sample) * $signed({1'b0, gain_mult(volume_mute_control[6:0])});
        if ($signed(prod[26:8]) > 19'sd32767) begin
            gained = 16'h7FFF;
        end else if ($signed(prod[26:8]) < -19'sd32768) begin
            gained = 16'h8000;
        end else begin
            gained = prod[23:8];
        end
        gained = gained ^ 16'h8000; // offset binary: 8000h is silence
    end

    // address and data channels are captured independently
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            aw_held <= 1'b0;
            aw_addr <= 5'h00;
            w_held <= 1'b0;
            w_byte <= 8'h00;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_byte <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_bresp = 2'b00;

    // register writes; a write without lane 0 strobe leaves the register
    logic wstrb_seen;
    wire wr_lane = do_write && wstrb_seen;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wstrb_seen <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wstrb_seen <= s_axi_wstrb[0];
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            volume_mute_control <= `APWM_RST_BYTE;
            ctrl <= '0;
            play_sample_low_byte <= `APWM_RST_BYTE;
            play_sample_high_byte <= `APWM_RST_BYTE;
            sample <= 16'h0000;
        end else if (wr_lane) begin
            case (aw_addr)
                5'(`APWM_OFF_VOLUME): volume_mute_control <= w_byte;
                5'(`APWM_OFF_CONTROL): ctrl <= {w_byte[7:5], w_byte[0]};
                5'(`APWM_OFF_SAMPLE_LO): play_sample_low_byte <= w_byte;
                5'(`APWM_OFF_SAMPLE_HI): begin
                    play_sample_high_byte <= w_byte;
                    sample <= {w_byte, play_sample_low_byte};
                end
                default: ;
            endcase
        end
    end

    // read channel; unmapped offsets answer okay with zero
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            case (rd_addr)
                5'(`APWM_OFF_VOLUME): s_axi_rdata <= {24'h0, volume_mute_control};
                5'(`APWM_OFF_CONTROL): s_axi_rdata <= {24'h0, ctrl_rd};
                5'(`APWM_OFF_SAMPLE_LO): s_axi_rdata <= {24'h0, play_sample_low_byte};
                5'(`APWM_OFF_SAMPLE_HI): s_axi_rdata <= {24'h0, play_sample_high_byte};
                `APWM_OFF_STATUS: s_axi_rdata <= {21'h0, active, state, duty[6:0]} ;
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp = 2'b00;

    // pin sequencer: green mode swaps the driven pin each period
    always_comb begin
        case (state)
            APWM_OFF: next_state = active ? APWM_RUN_A : APWM_OFF;
            APWM_RUN_A: next_state = !active ? APWM_OFF
                : (ctrl.mode && period_end) ? APWM_RUN_B : APWM_RUN_A;
            APWM_RUN_B: next_state = !active ? APWM_OFF
                : (period_end || !ctrl.mode) ? APWM_RUN_A : APWM_RUN_B;
            default: next_state = APWM_OFF;
        endcase
    end

    // counter and duty reload at period boundary to avoid glitched pulses
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state <= APWM_OFF;
            pwm_cnt <= 9'h000;
            duty <= 9'h000;
        end else begin
            state <= next_state;
            if (!active || period_end) begin
                pwm_cnt <= 9'h000;
                duty <= duty_next;
            end else begin
                pwm_cnt <= pwm_cnt + 9'h001;
            end
        end
    end

    // outputs registered; oe_n high floats the pin
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            speaker_out_a <= 1'b0;
            speaker_out_b <= 1'b0;
            speaker_out_a_oe_n <= 1'b1;
            speaker_out_b_oe_n <= 1'b1;
        end else begin
            speaker_out_a <= active && pwm_level;
            speaker_out_b <= active && pwm_level;
            speaker_out_a_oe_n <= !(active && (!ctrl.mode || state == APWM_RUN_A));
            speaker_out_b_oe_n <= !(active && (!ctrl.mode || state == APWM_RUN_B));
        end
    end

    a_float_when_off: assert property (@(posedge mclk) disable iff (!reset_n)
        !active |=> speaker_out_a_oe_n && speaker_out_b_oe_n)
        else $error("pins driven while off");
    a_sleep_kills: assert property (@(posedge mclk) disable iff (!reset_n)
        cpu_sleep |=> speaker_out_a_oe_n && speaker_out_b_oe_n)
        else $error("pins driven in sleep");
    a_normal_both: assert property (@(posedge mclk) disable iff (!reset_n)
        active && !ctrl.mode |=> !speaker_out_a_oe_n && !speaker_out_b_oe_n)
        else $error("normal mode not driving both");
    a_green_alternate: assert property (@(posedge mclk) disable iff (!reset_n)
        active && ctrl.mode |=> speaker_out_a_oe_n || speaker_out_b_oe_n)
        else $error("green mode drives both");
    a_mute_value: assert property (@(posedge mclk) disable iff (!reset_n)
        !volume_mute_control[`APWM_BIT_UNMUTE] |-> play_value == `APWM_MUTE_VALUE)
        else $error("mute value wrong");
    a_ctrl_zero: assert property (@(posedge mclk) disable iff (!reset_n)
        s_axi_rvalid && $past(rd_addr) == 5'(`APWM_OFF_CONTROL) && $rose(s_axi_rvalid)
        |-> s_axi_rdata[4:1] == 4'h0)
        else $error("control unused bits nonzero");
    a_sample_commit: assert property (@(posedge mclk) disable iff (!reset_n)
        wr_lane && aw_addr == 5'(`APWM_OFF_SAMPLE_HI)
        |=> sample == {play_sample_high_byte, play_sample_low_byte})
        else $error("sample not committed");
    a_duty_width: assert property (@(posedge mclk) disable iff (!reset_n)
        duty_next <= top_count)
        else $error("duty exceeds resolution");
    a_unity_gain: assert property (@(posedge mclk) disable iff (!reset_n)
        volume_mute_control[6:0] == `APWM_GAIN_UNITY |-> gained == (sample ^ 16'h8000))
        else $error("unity gain wrong");
    c_green_run: cover property (@(posedge mclk) state == APWM_RUN_B);
    c_sleep_off: cover property (@(posedge mclk) $rose(cpu_sleep) && ctrl.enable);
    c_hi_write: cover property (@(posedge mclk) wr_lane && aw_addr == 5'(`APWM_OFF_SAMPLE_HI));
endmodule

// ### apwm_map.svh
// Purpose: register offsets, field positions, reset values and constants of the audio pwm driver
// Assumes: axi4-lite byte addresses, one register per aligned word
// Notes: definitions only
`ifndef APWM_MAP_SVH
`define APWM_MAP_SVH
`define APWM_OFF_VOLUME 5'h00
`define APWM_OFF_CONTROL 5'h04
`define APWM_OFF_SAMPLE_LO 5'h08
`define APWM_OFF_SAMPLE_HI 5'h0C
`define APWM_OFF_STATUS 5'h10
`define APWM_BIT_UNMUTE 7
`define APWM_BIT_MODE 7
`define APWM_BIT_ENABLE 0
`define APWM_RST_BYTE 8'h00
`define APWM_MUTE_VALUE 16'h8000
`define APWM_GAIN_UNITY 7'h00
`define APWM_GAIN_TOP 7'h0C
`define APWM_GAIN_HALF_LOW 7'h68
`define APWM_GAIN_FLOOR 7'h54
`define APWM_CTRL_MASK 8'hE1
`endif

// ### apwm_pkg.sv
// Purpose: types shared by the audio pwm driver
// Assumes: nothing beyond the map header
// Notes: states are one-hot
package apwm_pkg;
    typedef enum logic [2:0] {
        APWM_OFF = 3'b001,
        APWM_RUN_A = 3'b010,
        APWM_RUN_B = 3'b100
    } apwm_state_t;
    typedef struct packed {
        logic mode;
        logic [1:0] res_sel;
        logic enable;
    } apwm_ctrl_t;
endpackage

// ### apwm_speaker_model.sv
// Purpose: loudspeaker load seen from the two driver pins
// Assumes: pins sampled on the mclk rising edge
// Notes: a floated pin shows the inverse of its last level
`timescale 1ns/1ns
module apwm_speaker_model (
    input wire logic mclk,
    input wire logic out_a,
    input wire logic oe_n_a,
    input wire logic out_b,
    input wire logic oe_n_b,
    input wire logic meas_start,
    input wire logic [15:0] meas_len,
    output logic meas_done,
    output logic [63:0] meas_val,
    output logic line_a,
    output logic line_b
);
    logic [15:0] left = 16'h0;
    logic [15:0] drv_a, drv_b, hi_a, hi_b;
    logic last_a = 1'h0;
    logic last_b = 1'h0;
    // a floated pin has no level; the opposite of the last one keeps x-free sims honest
    assign line_a = oe_n_a ? ~last_a : out_a;
    assign line_b = oe_n_b ? ~last_b : out_b;
    assign meas_val = {drv_a, drv_b, hi_a, hi_b};
    // count driven and driven-high cycles per pin over one window
    always @(posedge mclk) begin
        last_a <= line_a;
        last_b <= line_b;
        meas_done <= 1'h0;
        if (meas_start) begin
            left <= meas_len;
            {drv_a, drv_b, hi_a, hi_b} <= 64'h0;
        end else if (left != 16'h0) begin
            left <= left - 16'h1;
            drv_a <= drv_a + 16'(!oe_n_a);
            drv_b <= drv_b + 16'(!oe_n_b);
            hi_a <= hi_a + 16'(line_a & !oe_n_a);
            hi_b <= hi_b + 16'(line_b & !oe_n_b);
            meas_done <= (left == 16'h1);
        end
    end
endmodule

// ### audio_pwm_speaker_driver_tb_top.sv
// Purpose: self-checking bench for the audio pwm driver
// Assumes: axi4-lite master, one access at a time
// Notes: duty measured over whole periods, so phase does not matter
`timescale 1ns/1ns
`include "apwm_map.svh"
`define CHK(e, a) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
    $display("[ERR] t=%0t exp=%h got=%h", $time, e, a); end end
module audio_pwm_speaker_driver_tb_top
    import apwm_pkg::*;
;
    logic mclk, reset_n, cpu_sleep, awvalid, wvalid, bready, arvalid, rready, mstart;
    logic [4:0] awaddr, araddr;
    logic [7:0] wbyte;
    logic [15:0] mlen, smp, d;
    wire logic awready, wready, bvalid, arready, rvalid, mdone, sa, sb, sa_oe_n, sb_oe_n;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [63:0] mval;
    logic [63:0] exp_q[$];
    logic [7:0] gains[3] = '{8'h0C, 8'h68, 8'h54};
    int fail_count, cmp_count, n, p;

    apwm_driver dut (.mclk(mclk), .reset_n(reset_n), .cpu_sleep(cpu_sleep),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata({24'h0, wbyte}), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .speaker_out_a(sa),
        .speaker_out_a_oe_n(sa_oe_n), .speaker_out_b(sb), .speaker_out_b_oe_n(sb_oe_n));
    apwm_speaker_model spk (.mclk(mclk), .out_a(sa), .oe_n_a(sa_oe_n), .out_b(sb),
        .oe_n_b(sb_oe_n), .meas_start(mstart), .meas_len(mlen), .meas_done(mdone),
        .meas_val(mval), .line_a(), .line_b());

    initial begin
        mclk = 1'h0;
        forever #25 mclk = ~mclk;
    end
    function automatic logic [7:0] ctl(input apwm_ctrl_t c);
        return {c.mode, c.res_sel, 4'h0, c.enable};
    endfunction
    // expected duty: offset binary, top n bits only
    function automatic logic [15:0] duty(input logic [15:0] s, input int nb);
        return (s ^ 16'h8000) >> (16 - nb);
    endfunction
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        @(posedge mclk);
        awaddr <= a;
        wbyte <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] v);
        exp_q.push_back({56'h0, v});
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'h0;
        end while (!rvalid);
        rready <= 1'h0;
    endtask
    task automatic meas(input int len, input logic [63:0] e);
        exp_q.push_back(e);
        @(posedge mclk);
        mlen <= 16'(len);
        mstart <= 1'h1;
        @(posedge mclk);
        mstart <= 1'h0;
        do @(posedge mclk); while (!mdone);
    endtask
    task automatic test_done();
        $display("counts: compares=%0d mismatches=%0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // watcher: oldest note against each read or measurement that completes
    always @(posedge mclk) begin
        logic [63:0] e_now;
        if (bvalid && bready) `CHK(2'h0, bresp)
        if ((rvalid && rready) || mdone) begin
            e_now = exp_q.pop_front();
            if (mdone) `CHK(e_now, mval)
            else `CHK(e_now, {30'h0, rresp, rdata})
        end
    end
    initial begin
        repeat (40000) @(posedge mclk);
        fail_count++;
        test_done();
    end
    initial begin
        {reset_n, cpu_sleep, awvalid, wvalid, bready, arvalid, rready, mstart} = 8'h0;
        {awaddr, araddr, wbyte, mlen} = 34'h0;
        smp = 16'($urandom(32'h66d596dd));
        repeat (20) @(posedge mclk);
        reset_n <= 1'h1;
        for (n = 0; n < 6; n++) if (n != 4) rd(5'(n * 4), 8'h00);
        wr(`APWM_OFF_CONTROL, 8'hFE);
        rd(`APWM_OFF_CONTROL, 8'hE0);
        meas(64, 64'h0);
        // each code is read back before the next one overwrites it
        for (n = 0; n < 3; n++) begin
            wr(`APWM_OFF_VOLUME, gains[n]);
            rd(`APWM_OFF_VOLUME, gains[n]);
        end
        $display("test registers done");
        wr(`APWM_OFF_VOLUME, 8'h00);
        for (n = 6; n < 10; n++) begin
            p = 1 << n;
            wr(`APWM_OFF_CONTROL, ctl('{1'h0, 2'(n - 6), 1'h1}));
            repeat (2 * p) @(posedge mclk);
            meas(p, {16'(p), 16'(p), 16'(p / 2), 16'(p / 2)});
        end
        $display("test mute done");
        wr(`APWM_OFF_VOLUME, 8'h80);
        for (n = 6; n < 10; n++) begin
            p = 1 << n;
            wr(`APWM_OFF_CONTROL, ctl('{1'h0, 2'(n - 6), 1'h1}));
            smp = 16'($urandom);
            wr(`APWM_OFF_SAMPLE_LO, smp[7:0]);
            wr(`APWM_OFF_SAMPLE_HI, smp[15:8]);
            d = duty(smp, n);
            repeat (2 * p) @(posedge mclk);
            meas(p, {16'(p), 16'(p), d, d});
            wr(`APWM_OFF_SAMPLE_LO, ~smp[7:0]);
            repeat (2 * p) @(posedge mclk);
            meas(p, {16'(p), 16'(p), d, d});
        end
        $display("test play done");
        // -6 dB code halves the signed sample; 9-bit resolution still selected
        wr(`APWM_OFF_VOLUME, 8'hF4);
        smp = 16'($signed(smp) >>> 1);
        d = duty(smp, 9);
        repeat (1024) @(posedge mclk);
        meas(512, {16'h200, 16'h200, d, d});
        $display("test gain done");
        wr(`APWM_OFF_CONTROL, ctl('{1'h1, 2'h0, 1'h1}));
        d = duty(smp, 6);
        repeat (256) @(posedge mclk);
        meas(128, {16'h40, 16'h40, d, d});
        $display("test green done");
        cpu_sleep <= 1'h1;
        repeat (8) @(posedge mclk);
        meas(128, 64'h0);
        cpu_sleep <= 1'h0;
        $display("test sleep done");
        test_done();
    end
endmodule
